// ===== occ_pkg.sv
// Purpose: constants and types for the clock configuration word decoder
// Assumes: one 32-bit configuration word, registers on a 32-bit avalon slave
// Notes: field positions and codes follow the word layout
package occ_pkg;
  // field positions in clock_config_word
  localparam int SRC_LSB = 0;
  localparam int SEC_OSC_BIT = 5;
  localparam int TWO_SPEED_BIT = 7;
  localparam int PRI_MODE_LSB = 8;
  localparam int CLKOUT_N_BIT = 10;
  localparam int DIV_LSB = 12;
  localparam int SWMON_LSB = 14;
  localparam logic [31:0] RSVD_MASK = 32'h0000_0858;
  localparam logic [31:0] CFG_WORD_DEFAULT = 32'hffff_ffff;
  // register byte addresses
  localparam logic [3:0] ADDR_CFG = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_CTRL = 4'h8;
  // status field positions
  localparam int ST_SRC_LSB = 0;
  localparam int ST_PRI_LSB = 4;
  localparam int ST_DIV_LSB = 8;
  localparam int ST_SWITCH_BIT = 12;
  localparam int ST_MONITOR_BIT = 13;
  localparam int ST_TWO_SPEED_BIT = 14;
  localparam int ST_SEC_OSC_BIT = 15;
  localparam int ST_CLKOUT_BIT = 16;
  localparam int ST_RSVD_OK_BIT = 17;
  localparam int ST_POSC_CONFLICT_BIT = 18;
  localparam int CTRL_RECAPTURE_BIT = 0;

  typedef enum logic [2:0] {
    OCC_SRC_FRC = 3'h0,
    OCC_SRC_FRC_DIV_PLL = 3'h1,
    OCC_SRC_PRI = 3'h2,
    OCC_SRC_PRI_PLL = 3'h3,
    OCC_SRC_SEC = 3'h4,
    OCC_SRC_LOW_POWER_RC_OSCILLATOR = 3'h5,
    OCC_SRC_FRC_DIV16 = 3'h6,
    OCC_SRC_FRC_DIV = 3'h7
  } occ_src_t;

  typedef enum logic [1:0] {
    OCC_PRI_EXT_CLK = 2'h0,
    OCC_PRI_STD_XTAL = 2'h1,
    OCC_PRI_HS_XTAL = 2'h2,
    OCC_PRI_OFF = 2'h3
  } occ_pri_t;

  typedef struct packed {
    occ_src_t src;
    occ_pri_t pri_mode;
    logic [1:0] div_log2;
    logic switch_en;
    logic monitor_en;
    logic two_speed_en;
    logic sec_osc_en;
    logic clkout_en;
    logic rsvd_ok;
    logic posc_conflict;
  } occ_dec_t;

  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } occ_av_req_t;
endpackage : occ_pkg

// ===== occ_field_decode.sv
// Purpose: pure decode of the clock configuration word into settings
// Assumes: word is stable from a register
// Notes: combinational only
`timescale 1ns/100ps
module occ_field_decode
  import occ_pkg::*;
(
  input wire logic [31:0] word,
  output occ_dec_t dec
);
  always_comb begin
    dec.src = occ_src_t'(word[SRC_LSB +: 3]);
    dec.pri_mode = occ_pri_t'(word[PRI_MODE_LSB +: 2]);
    dec.div_log2 = word[DIV_LSB +: 2];
    dec.switch_en = ~word[SWMON_LSB + 1];
    dec.monitor_en = (word[SWMON_LSB +: 2] == 2'h0);
    dec.two_speed_en = word[TWO_SPEED_BIT];
    dec.sec_osc_en = word[SEC_OSC_BIT];
    // clock out only when pins are not taken by a crystal
    dec.clkout_en = ~word[CLKOUT_N_BIT]
      && (dec.pri_mode == OCC_PRI_OFF || dec.pri_mode == OCC_PRI_EXT_CLK);
    dec.rsvd_ok = ((word & RSVD_MASK) == RSVD_MASK);
    dec.posc_conflict = (dec.pri_mode == OCC_PRI_OFF)
      && (dec.src == OCC_SRC_PRI || dec.src == OCC_SRC_PRI_PLL);
  end
endmodule : occ_field_decode

// ===== occ_clock_config.sv
// Purpose: captures the clock configuration word and drives clock setup
// Assumes: nv_word comes from configuration storage on the same clock
// Notes: settings change only at capture
//
// What this block does
// - two-bit field sets switching and fail-safe monitor
// - divisor code sets peripheral clock divide 1..8
// - clock out only if enabled, pins free
// - primary mode: off, fast, standard, external clock
// - switchover bit enables two-speed start-up
// - secondary oscillator follows its enable bit
// - upper source codes select rc or secondary
// - lower source codes select primary or rc
`timescale 1ns/100ps
module occ_clock_config
  import occ_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] nv_word,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [2:0] initial_clock_source,
  output logic [1:0] primary_osc_mode,
  output logic [3:0] periph_bus_divisor,
  output logic clock_switch_en,
  output logic fail_safe_monitor_en,
  output logic two_speed_startup_en,
  output logic secondary_osc_en,
  output logic clock_output_en,
  output logic config_fault
);
  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic captured;
    logic [31:0] word;
    logic resp_pending;
    logic [31:0] rdata;
  } occ_state_t;

  occ_state_t st;
  occ_state_t next_st;
  occ_dec_t dec;
  occ_av_req_t req;

  assign req = '{address: avs_address, read: avs_read, write: avs_write,
                 writedata: avs_writedata};

  occ_field_decode u_dec (
    .word(st.word),
    .dec(dec)
  );

  ////////////////////////////////////////////////////////////////////////
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_SRC_LSB +: 3] = dec.src;
    status_word[ST_PRI_LSB +: 2] = dec.pri_mode;
    status_word[ST_DIV_LSB +: 2] = dec.div_log2;
    status_word[ST_SWITCH_BIT] = dec.switch_en;
    status_word[ST_MONITOR_BIT] = dec.monitor_en;
    status_word[ST_TWO_SPEED_BIT] = dec.two_speed_en;
    status_word[ST_SEC_OSC_BIT] = dec.sec_osc_en;
    status_word[ST_CLKOUT_BIT] = dec.clkout_en;
    status_word[ST_RSVD_OK_BIT] = dec.rsvd_ok;
    status_word[ST_POSC_CONFLICT_BIT] = dec.posc_conflict;
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    // first cycle after reset latches the word; later only on request
    if (!st.captured) begin
      next_st.word = nv_word;
      next_st.captured = 1'b1;
    end
    // one wait cycle per access: request taken, answer next edge
    if (st.resp_pending) begin
      next_st.resp_pending = 1'b0;
      // write lands at the completing edge, when the master sees waitrequest low
      if (req.write && req.address == ADDR_CTRL && req.writedata[CTRL_RECAPTURE_BIT]) begin
        next_st.captured = 1'b0;
      end
    end else if (req.read || req.write) begin
      next_st.resp_pending = 1'b1;
      next_st.rdata = 32'h0000_0000;
      if (req.read) begin
        case (req.address)
          ADDR_CFG: next_st.rdata = st.word;
          ADDR_STATUS: next_st.rdata = status_word;
          default: next_st.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '{captured: 1'b0, word: CFG_WORD_DEFAULT, resp_pending: 1'b0,
              rdata: 32'h0000_0000};
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign avs_waitrequest = (avs_read || avs_write) && !st.resp_pending;
  assign avs_readdata = st.rdata;
  assign initial_clock_source = dec.src;
  assign primary_osc_mode = dec.pri_mode;
  assign periph_bus_divisor = 4'h1 << dec.div_log2;
  assign clock_switch_en = dec.switch_en;
  assign fail_safe_monitor_en = dec.monitor_en;
  assign two_speed_startup_en = dec.two_speed_en;
  assign secondary_osc_en = dec.sec_osc_en;
  assign clock_output_en = dec.clkout_en;
  // flags a word that breaks reserved bits or disables the active primary
  assign config_fault = dec.posc_conflict || !dec.rsvd_ok;
endmodule : occ_clock_config

// ===== occ_checker.sv
// Purpose: watches decoded clock settings against the captured word
// Assumes: the word is recaptured by reset or by a completed control write
// Notes: cw mirrors the capture at the first edge after reset
`timescale 1ns/100ps
module occ_checker
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] nv_word,
  input wire logic [3:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic [2:0] initial_clock_source,
  input wire logic [1:0] primary_osc_mode,
  input wire logic [3:0] periph_bus_divisor,
  input wire logic clock_switch_en,
  input wire logic fail_safe_monitor_en,
  input wire logic two_speed_startup_en,
  input wire logic secondary_osc_en,
  input wire logic clock_output_en
);
  logic cv;
  logic [31:0] cw;
  wire ce = !cw[10] && cw[8] == cw[9];
  wire [1:0] sm = {!cw[15], cw[15:14] == 2'h0};
  wire [8:0] st = {initial_clock_source, primary_osc_mode, periph_bus_divisor};
  // completed control write with the recapture bit set
  wire rec = avs_write && !avs_waitrequest && avs_address == 4'h8 && avs_writedata[0];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk) begin
    cv <= !rst && !rec;
    if (!rst && !cv) cw <= nv_word;
  end
  a_src_decode: assert property (cv |-> initial_clock_source == cw[2:0]) else $error("src");
  a_pri_mode: assert property (cv |-> primary_osc_mode == cw[9:8]) else $error("pri");
  a_bus_div: assert property (cv |-> periph_bus_divisor == 4'h1 << cw[13:12]) else $error("div");
  a_switch_mon: assert property (cv |-> {clock_switch_en, fail_safe_monitor_en} == sm)
    else $error("swmon");
  a_clkout_gate: assert property (cv |-> clock_output_en == ce) else $error("clkout");
  a_two_speed: assert property (cv |-> two_speed_startup_en == cw[7]) else $error("2spd");
  a_sec_osc: assert property (cv |-> secondary_osc_en == cw[5]) else $error("sosc");
  a_held_static: assert property (cv && $past(cv) |-> $stable(st)) else $error("moved");
  c_pll: cover property (cv && initial_clock_source == 3'h3);
  c_clkout: cover property (clock_output_en);
  c_monitor: cover property (fail_safe_monitor_en);
  c_recapture: cover property (rec);
endmodule : occ_checker

// ===== occ_nv_model.sv
// Purpose: configuration storage feeding the word
// Assumes: legal low passes a raw word for fault tests
// Notes: combinational
`timescale 1ns/100ps
module occ_nv_model
  import occ_pkg::*;
(
  input wire logic [31:0] raw,
  input wire logic legal,
  output logic [31:0] nv_word
);
  logic [31:0] f;
  always_comb begin
    f = raw | RSVD_MASK;
    if (f[2:1] == 2'h1) f[8] = 1'b0;
    nv_word = legal ? f : raw;
  end
endmodule : occ_nv_model

// ===== tb_oscillator_config_word_decode.sv
// Purpose: captures words through reset and reads the registers back
// Assumes: nv_word changes after capture must not leak in
// Notes: status expectation built from the field layout
`timescale 1ns/100ps
module tb_oscillator_config_word_decode;
  import occ_pkg::*;
  logic clk, avs_waitrequest, clock_switch_en, fail_safe_monitor_en, two_speed_startup_en;
  logic secondary_osc_en, clock_output_en, config_fault;
  logic rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, legal = 1'b1;
  logic [31:0] nv_word, avs_readdata, raw = 32'hffff_ffff, avs_writedata = 32'h0;
  logic [3:0] avs_address = 4'h0, periph_bus_divisor;
  logic [2:0] initial_clock_source;
  logic [1:0] primary_osc_mode;
  logic [31:0] q[$];
  int n_mismatch, num_checks;
  occ_clock_config i_dut (.*);
  occ_nv_model i_nv (.*);
  //////////////////////////////////////////////////
  function automatic logic [31:0] stat(input logic [31:0] w);
    return {13'h0, w[2:1] == 2'h1 && w[9:8] == 2'h3, (w & RSVD_MASK) == RSVD_MASK,
      !w[10] && w[8] == w[9], w[5], w[7], w[15:14] == 2'h0, !w[15], 2'h0, w[13:12],
      2'h0, w[9:8], 1'h0, w[2:0]};
  endfunction : stat
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic bus(input logic [3:0] a, input logic rd, input logic [31:0] d);
    int k;
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= d;
    k = 0;
    do begin @(posedge clk); k++; end while (avs_waitrequest !== 1'b0 && k < 20);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 20) begin n_mismatch++; conclude(); end
    @(posedge clk);
  endtask : bus
  // empty queue here means the slave answered a read nobody made
  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (q.size() == 0) chk(32'hdead_beef, avs_readdata);
      else chk(q.pop_front(), avs_readdata);
    end
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    logic [31:0] w;
    logic [31:0] s;
    void'($urandom(99623));
    repeat (6) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      w = $urandom();
      w[2:0] = i[2:0];
      w[9:8] = i[1:0];
      w[15:12] = {i[1:0], i[1:0]};
      raw <= w;
      legal <= (i % 3 != 0);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      w = nv_word;
      raw <= ~w;
      q.push_back(stat(w));
      bus(ADDR_STATUS, 1'b1, 32'h0);
      bus(ADDR_CFG, 1'b0, ~w);
      q.push_back(w);
      bus(ADDR_CFG, 1'b1, 32'h0);
      q.push_back(32'h0);
      bus(4'hc, 1'b1, 32'h0);
      // fresh word taken only through the control register
      raw <= $urandom();
      bus(ADDR_CTRL, 1'b0, 32'h1);
      w = nv_word;
      q.push_back(w);
      bus(ADDR_CFG, 1'b1, 32'h0);
      s = stat(w);
      chk({31'h0, !s[17] || s[18]}, {31'h0, config_fault});
    end
    conclude();
  end
endmodule : tb_oscillator_config_word_decode
bind occ_clock_config occ_checker i_chk (.*);
